/* watchdog_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the watchdog block.
  Assumes inclusion by its bare name from every file that needs a constant.
*/
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH
// ==========================================================
// Register byte addresses on the bus
`define ADDR_CONTROL 8'h00
`define ADDR_FLAGS 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_THRESHOLD 8'h0c
`define ADDR_OPTION 8'h10
// ==========================================================
// Fields and reset values
`define CONTROL_RESET 8'h53
`define KEY_MSB 7
`define KEY_LSB 3
`define PSEL_MSB 2
`define KEY_ENABLE 5'h0a
`define KEY_DISABLE 5'h15
`define SYSCLK_IN_IDLE_ENABLE_BIT 7
`define LOW_VOLTAGE_RESET_FLAG_BIT 2
`define LRF_BIT 1
`define WRF_BIT 0
`define STAT_TO_BIT 0
`define STAT_PDF_BIT 1
`define STAT_EN_BIT 2
`define THRESH_RESET 8'h55
`define THRESH_CODE_A 8'h55
`define THRESH_CODE_B 8'h33
`define THRESH_CODE_C 8'h99
`define THRESH_CODE_D 8'haa
`define OPTION_RESET 8'h02
`define OPT_ALWAYS_BIT 0
`define OPT_PIN_BIT 1
// ==========================================================
// Divide exponents, select 7 in the top slot, select 0 at the bottom
`define WDT_WIDTH 18
`define WDT_EXPONENTS {5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0c, 5'h0a, 5'h08}
// ==========================================================
// Timing
`define CLK_KHZ 20000
`define SLOW_KHZ 32
`define RESET_DELAY_MS 50
`define BAD_TICKS 3
`endif

/* wdt_pkg.sv */
/*
  Types shared by the watchdog block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wdt_pkg;
  typedef logic [31:0] wb_data_t;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {RST_HOLD, RST_DELAY, RST_RUN} reset_state_t;
endpackage

/* wdt_sync3.sv */
/*
  Three-stage synchroniser for one pin level.
  Assumes an asynchronous input; the output moves only when stages two and three agree.
*/
`timescale 1ns/100ps
module wdt_sync3 #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic ff1;
  logic ff2;
  logic ff3;

  // ==========================================================
  // Stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff1 <= INIT;
      ff2 <= INIT;
      ff3 <= INIT;
    end else begin
      ff1 <= d_i;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Agreement filter rejects a one-cycle glitch at the boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= INIT;
    end else if (ff2 == ff3) begin
      q_o <= ff3;
    end
  end
endmodule

/* wdt_counter.sv */
/*
  Watchdog up-counter with selectable overflow stage.
  Assumes tick_i is a one-cycle enable at the slow oscillator rate.
*/
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module wdt_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [2:0] period_select_i,
  output logic [`WDT_WIDTH-1:0] count_o,
  output logic overflow_o
);
  localparam logic [39:0] EXPS = `WDT_EXPONENTS;
  logic [4:0] stage;
  logic [`WDT_WIDTH-1:0] mask;

  // ==========================================================
  // Stage mask
  assign stage = EXPS[period_select_i*5 +: 5];
  genvar i;
  generate
    for (i = 0; i < `WDT_WIDTH; i = i + 1) begin : g_mask
      assign mask[i] = (5'(i) < stage); // RQ1
    end
  endgenerate

  // ==========================================================
  // Count and overflow
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= '0;
    end else if (tick_i && enable_i) begin
      count_o <= count_o + 1'b1; // RQ22
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= tick_i && enable_i && !clear_i && ((count_o & mask) == mask); // RQ1
    end
  end

  chk_overflow_wraps: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    overflow_o && !$past(clear_i) |-> ((count_o & mask) == '0))
    else $error("overflow without low stages wrapping");
  chk_disabled_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
    !enable_i && !clear_i |=> $stable(count_o))
    else $error("counter moved while disabled");
endmodule

/* watchdog_with_reset_flags.sv */
/*
  Watchdog timer with keyed enable, reset sequencer and sticky reset-cause flags.
  Assumes a classic Wishbone master, core pulses for halt and clear instructions,
  and asynchronous pins for the shared reset bit and the low-voltage detector.
*/
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
// Contract
// RQ1 - Period select picks overflow at 2^8,10,12,14,15,16,17,18 slow periods
// RQ2 - Enabled counter overflow resets the device unless cleared first
// RQ3 - Always-on option runs watchdog for either legal key code
// RQ4 - Register option disables on 10101B and enables on 01010B
// RQ5 - Illegal key forces full reset after two to three slow cycles
// RQ6 - Key field holds 01010B after power-on
// RQ7 - Illegal key reset sets key flag; only software write 0 clears
// RQ8 - Low-voltage reset sets its flag until software clears it
// RQ9 - Undefined threshold code sets its flag and acts as reset
// RQ10 - Timeout in normal running causes full reset and sets timeout flag
// RQ11 - Timeout in low power sets flag, clears only PC and stack pointer
// RQ12 - Counter clears on key reset, clear instruction or halt
// RQ13 - Only the clear instruction clears the counter from software
// RQ14 - Idle clock bit keeps system clock running in idle when set
// RQ15 - Flag register bits 6 to 3 read zero
// RQ16 - Execution waits the power-on delay after power-on
// RQ17 - Power-on reset forces the program counter to zero
// RQ18 - Power-on reset presets port data and direction high
// RQ19 - Reset shares a port pin, chosen by an option bit
// RQ20 - Low reset pin holds the core, then a reset delay follows
// RQ21 - Halt sets power-down flag, clear instruction or power-up clears it
// RQ22 - Watchdog is an 18-bit slow-clock counter tapped by period select
// RQ23 - Illegal key is debounced by a small slow-clock counter
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module watchdog_with_reset_flags #(
  parameter int RESET_DELAY_CYCLES = `RESET_DELAY_MS * `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire wdt_pkg::wb_data_t dat_i,
  output wdt_pkg::wb_data_t dat_o,
  output logic ack_o,
  input wire logic halt_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic halted_i,
  input wire logic idle_mode_i,
  input wire logic reset_pin_i,
  input wire logic lvr_event_i,
  output logic core_reset_o,
  output logic pc_sp_clear_o,
  output logic port_preset_o,
  output logic port_bit_o,
  output logic sysclk_en_o
);
  import wdt_pkg::*;

  localparam int SLOW_DIV = `CLK_KHZ / `SLOW_KHZ;
  localparam int DW = $clog2(RESET_DELAY_CYCLES + 1);

  logic [9:0] div_cnt;
  logic slow_tick;
  reg8_t watchdog_control;
  reg8_t voltage_threshold_select;
  reg8_t option_reg;
  logic sysclk_in_idle_enable;
  logic low_voltage_reset_flag;
  logic threshold_reg_reset_flag;
  logic watchdog_key_reset_flag;
  logic timeout_flag;
  logic power_down_flag;
  logic bus_req;
  logic [7:0] word_addr;
  logic wr_take;
  logic wr_ctl;
  logic wr_flags;
  logic wr_thr;
  logic wr_opt;
  reg8_t rd_byte;
  logic [4:0] enable_key_field;
  logic [2:0] period_select;
  logic key_legal;
  logic wdt_enabled;
  logic [1:0] key_bad_cnt;
  logic key_fire;
  logic thr_legal;
  logic [1:0] thr_bad_cnt;
  logic thr_fire;
  logic pin_level;
  logic lvr_level;
  logic lvr_prev;
  logic lvr_rise;
  logic pin_hold;
  logic wdt_ovf;
  logic [`WDT_WIDTH-1:0] wdt_count;
  logic full_cause;
  reset_state_t state;
  logic [DW-1:0] delay_cnt;
  logic por_phase;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Slow oscillator tick, a one-cycle enable from the system clock
  assign slow_tick = (div_cnt == 10'(SLOW_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || slow_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Bus slave: ack one cycle after the request, write lands on the ack edge
  assign bus_req = cyc_i && stb_i;
  assign word_addr = {adr_i[7:2], 2'b00};
  assign wr_take = bus_req && ack_o && we_i && sel_i[0];
  assign wr_ctl = wr_take && (word_addr == `ADDR_CONTROL);
  assign wr_flags = wr_take && (word_addr == `ADDR_FLAGS);
  assign wr_thr = wr_take && (word_addr == `ADDR_THRESHOLD);
  assign wr_opt = wr_take && (word_addr == `ADDR_OPTION);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req && !ack_o;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (word_addr)
      `ADDR_CONTROL: rd_byte = watchdog_control;
      `ADDR_FLAGS: begin // RQ15
        rd_byte[`SYSCLK_IN_IDLE_ENABLE_BIT] = sysclk_in_idle_enable;
        rd_byte[`LOW_VOLTAGE_RESET_FLAG_BIT] = low_voltage_reset_flag;
        rd_byte[`LRF_BIT] = threshold_reg_reset_flag;
        rd_byte[`WRF_BIT] = watchdog_key_reset_flag;
      end
      `ADDR_STATUS: begin
        rd_byte[`STAT_TO_BIT] = timeout_flag;
        rd_byte[`STAT_PDF_BIT] = power_down_flag;
        rd_byte[`STAT_EN_BIT] = wdt_enabled;
      end
      `ADDR_THRESHOLD: rd_byte = voltage_threshold_select;
      `ADDR_OPTION: rd_byte = option_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (bus_req && !ack_o) begin
      dat_o <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // Control register; an illegal key brings it back to its power-on value
  always_ff @(posedge clk_i) begin
    if (rst_i || key_fire) begin
      watchdog_control <= `CONTROL_RESET; // RQ6
    end else if (wr_ctl) begin
      watchdog_control <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || thr_fire) begin
      voltage_threshold_select <= `THRESH_RESET;
    end else if (wr_thr) begin
      voltage_threshold_select <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_reg <= `OPTION_RESET;
    end else if (wr_opt) begin
      option_reg <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Key decode and debounce
  assign enable_key_field = watchdog_control[`KEY_MSB:`KEY_LSB];
  assign period_select = watchdog_control[`PSEL_MSB:0];
  assign key_legal = (enable_key_field == `KEY_ENABLE) || (enable_key_field == `KEY_DISABLE);
  assign wdt_enabled = option_reg[`OPT_ALWAYS_BIT] ? key_legal // RQ3
                                                   : (enable_key_field == `KEY_ENABLE); // RQ4
  // Third tick after the change lands two to three slow periods later
  assign key_fire = !key_legal && slow_tick && (key_bad_cnt == 2'(`BAD_TICKS - 1)); // RQ5

  always_ff @(posedge clk_i) begin
    if (rst_i || key_legal || key_fire) begin
      key_bad_cnt <= 2'h0;
    end else if (slow_tick) begin
      key_bad_cnt <= key_bad_cnt + 2'h1; // RQ23
    end
  end

  assign thr_legal = (voltage_threshold_select == `THRESH_CODE_A) || (voltage_threshold_select == `THRESH_CODE_B)
                  || (voltage_threshold_select == `THRESH_CODE_C) || (voltage_threshold_select == `THRESH_CODE_D);
  assign thr_fire = !thr_legal && slow_tick && (thr_bad_cnt == 2'(`BAD_TICKS - 1)); // RQ9

  always_ff @(posedge clk_i) begin
    if (rst_i || thr_legal || thr_fire) begin
      thr_bad_cnt <= 2'h0;
    end else if (slow_tick) begin
      thr_bad_cnt <= thr_bad_cnt + 2'h1;
    end
  end

  // ==========================================================
  // Counter; software reaches the clear only through the clear instruction
  wdt_counter u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(slow_tick),
    .enable_i(wdt_enabled),
    .clear_i(key_fire || watchdog_clear_instruction_i || halt_i), // RQ12 RQ13
    .period_select_i(period_select),
    .count_o(wdt_count),
    .overflow_o(wdt_ovf)
  );

  // ==========================================================
  // Pins
  wdt_sync3 #(.INIT(1'b1)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(reset_pin_i),
    .q_o(pin_level)
  );
  wdt_sync3 #(.INIT(1'b0)) u_lvr_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(lvr_event_i),
    .q_o(lvr_level)
  );

  assign pin_hold = option_reg[`OPT_PIN_BIT] && !pin_level; // RQ19
  // Detector is off in power-down, so no event is taken then
  assign lvr_rise = lvr_level && !lvr_prev && !halted_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvr_prev <= 1'b0;
      port_bit_o <= 1'b1;
    end else begin
      lvr_prev <= lvr_level;
      port_bit_o <= pin_level;
    end
  end

  // ==========================================================
  // Sticky flags; a hardware set beats a same-cycle software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_key_reset_flag <= 1'b0;
    end else if (key_fire) begin
      watchdog_key_reset_flag <= 1'b1; // RQ7
    end else if (wr_flags && !dat_i[`WRF_BIT]) begin
      watchdog_key_reset_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_voltage_reset_flag <= 1'b0;
    end else if (lvr_rise) begin
      low_voltage_reset_flag <= 1'b1; // RQ8
    end else if (wr_flags && !dat_i[`LOW_VOLTAGE_RESET_FLAG_BIT]) begin
      low_voltage_reset_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_reg_reset_flag <= 1'b0;
    end else if (thr_fire) begin
      threshold_reg_reset_flag <= 1'b1; // RQ9
    end else if (wr_flags && !dat_i[`LRF_BIT]) begin
      threshold_reg_reset_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysclk_in_idle_enable <= 1'b0;
    end else if (wr_flags) begin
      sysclk_in_idle_enable <= dat_i[`SYSCLK_IN_IDLE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_flag <= 1'b0;
      power_down_flag <= 1'b0;
    end else begin
      if (wdt_ovf) begin
        timeout_flag <= 1'b1; // RQ10 RQ11
      end else if (halt_i || watchdog_clear_instruction_i) begin
        timeout_flag <= 1'b0;
      end
      if (halt_i) begin
        power_down_flag <= 1'b1; // RQ21
      end else if (watchdog_clear_instruction_i) begin
        power_down_flag <= 1'b0; // RQ21
      end
    end
  end

  // ==========================================================
  // Reset sequencer
  assign full_cause = key_fire || thr_fire || lvr_rise || (wdt_ovf && !halted_i); // RQ2 RQ10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RST_DELAY; // RQ16
      delay_cnt <= '0;
    end else if (pin_hold) begin
      state <= RST_HOLD; // RQ20
      delay_cnt <= '0;
    end else if (full_cause) begin
      state <= RST_DELAY;
      delay_cnt <= '0;
    end else begin
      case (state)
        RST_HOLD: begin
          state <= RST_DELAY; // RQ20
        end
        RST_DELAY: begin
          if (delay_cnt == DW'(RESET_DELAY_CYCLES - 1)) begin
            state <= RST_RUN;
          end else begin
            delay_cnt <= delay_cnt + 1'b1;
          end
        end
        RST_RUN: begin
          state <= RST_RUN;
        end
        default: begin
          state <= RST_HOLD;
        end
      endcase
    end
  end

  // Held reset keeps the program counter at zero
  assign core_reset_o = rst_i || (state != RST_RUN); // RQ17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_phase <= 1'b1; // RQ18
    end else if (state == RST_RUN) begin
      por_phase <= 1'b0;
    end
  end
  assign port_preset_o = por_phase;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_sp_clear_o <= 1'b0;
      sysclk_en_o <= 1'b1;
    end else begin
      pc_sp_clear_o <= wdt_ovf && halted_i; // RQ11
      sysclk_en_o <= !halted_i || (idle_mode_i && sysclk_in_idle_enable); // RQ14
    end
  end

  // ==========================================================
  // Checks
  chk_timeout_resets: assert property (wdt_ovf && !halted_i && !pin_hold |=> core_reset_o && timeout_flag) // RQ2
    else $error("normal timeout did not reset");
  chk_key_selects_run: assert property (option_reg[`OPT_ALWAYS_BIT] && key_legal |-> wdt_enabled) // RQ3
    else $error("always-on option left watchdog stopped");
  chk_key_disable: assert property (!option_reg[`OPT_ALWAYS_BIT] && (enable_key_field == `KEY_DISABLE) // RQ4
    |-> !wdt_enabled)
    else $error("disable key did not stop watchdog");
  chk_key_reset_delay: assert property (key_fire |-> $past(!key_legal, 1) && (key_bad_cnt == 2'h2)) // RQ5
    else $error("key reset fired without debounce");
  chk_key_power_on: assert property ($fell(rst_i) |-> enable_key_field == `KEY_ENABLE) // RQ6
    else $error("key field wrong after power-on");
  chk_key_flag_sticky: assert property (watchdog_key_reset_flag && !wr_flags |=> watchdog_key_reset_flag) // RQ7
    else $error("key flag dropped without software");
  chk_key_flag_set: assert property (key_fire |=> watchdog_key_reset_flag && core_reset_o) // RQ7
    else $error("key reset did not set flag");
  chk_lvr_flag: assert property (lvr_rise |=> low_voltage_reset_flag) // RQ8
    else $error("low-voltage flag not set");
  chk_idle_timeout: assert property (wdt_ovf && halted_i |=> pc_sp_clear_o ##1 !pc_sp_clear_o) // RQ11
    else $error("sleep timeout did not pulse pc clear");
  chk_clear_instr: assert property (watchdog_clear_instruction_i |=> wdt_count == '0) // RQ12
    else $error("clear instruction left counter running");
  chk_flag_reserved: assert property (ack_o && (word_addr == `ADDR_FLAGS) |-> dat_o[6:3] == 4'h0) // RQ15
    else $error("reserved flag bits read nonzero");
  chk_idle_clock: assert property (halted_i && idle_mode_i && sysclk_in_idle_enable |=> sysclk_en_o) // RQ14
    else $error("idle clock stopped while enabled");
  chk_pin_holds: assert property (pin_hold |=> core_reset_o [*2]) // RQ20
    else $error("reset pin did not hold core");
  chk_halt_pdf: assert property (halt_i |=> power_down_flag && !timeout_flag || $past(wdt_ovf)) // RQ21
    else $error("halt did not set power-down flag");
endmodule

/* testbench.sv */
/*
  Self-checking bench for the watchdog block: bus access, keyed enable, reset causes.
  Assumes the design files are compiled first; the slow tick is 625 clocks in the design.
*/
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module testbench;
  import wdt_pkg::*;
  // ==========================================================
  // Clock, reset and design ports
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  wb_data_t dat_i = 32'h0;
  wb_data_t dat_o;
  logic ack_o, core_reset_o, pc_sp_clear_o, port_preset_o, port_bit_o, sysclk_en_o;
  logic halt_i = 1'b0;
  logic watchdog_clear_instruction_i = 1'b0;
  logic halted_i = 1'b0;
  logic idle_mode_i = 1'b0;
  logic reset_pin_i = 1'b1;
  logic lvr_event_i = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [7:0] r8;
  wb_data_t exp_q[$];
  always #25 clk_i = ~clk_i;
  // Short delay keeps each full reset at about twenty clocks
  watchdog_with_reset_flags #(.RESET_DELAY_CYCLES(20)) watchdog_with_reset_flags_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .halt_i(halt_i), .watchdog_clear_instruction_i(watchdog_clear_instruction_i), .halted_i(halted_i), .idle_mode_i(idle_mode_i),
    .reset_pin_i(reset_pin_i), .lvr_event_i(lvr_event_i), .core_reset_o(core_reset_o),
    .pc_sp_clear_o(pc_sp_clear_o), .port_preset_o(port_preset_o), .port_bit_o(port_bit_o),
    .sysclk_en_o(sysclk_en_o));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Classic cycle; read data is judged by the monitor at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'hf;
    k = 0;
    // No cap here: only the bench watchdog ends a hung wait
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1);
    check(k == 2, 1'b1, "bus ack latency");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  // Edges spent until the reset output reaches a level, bounded
  task automatic wait_rst(input logic lvl, output int cnt);
    cnt = 0;
    while (core_reset_o !== lvl && cnt < 3000) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 3000) check(1'b0, 1'b1, "reset wait limit");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Monitor: oldest expected read value against each read ack
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) check(dat_o, 32'hffff_ffff, "unexpected read");
      else check(dat_o, exp_q.pop_front(), "read data");
    end
  end
  initial begin
    #(50 * 20000);
    num_errors++;
    final_report();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(42));
    repeat (8) @(posedge clk_i);
    check(core_reset_o, 1'b1, "reset held");
    check(port_preset_o, 1'b1, "ports preset");
    rst_i <= 1'b0;
    wait_rst(1'b0, n);
    check(n >= 19 && n <= 22, 1'b1, "start delay");
    repeat (2) @(posedge clk_i);
    check(port_preset_o, 1'b0, "preset released");
    rd(`ADDR_CONTROL, `CONTROL_RESET);
    rd(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_STATUS, 8'h04);
    rd(8'h14, 8'h00);
    $display("test reset done");
    bus(1'b1, `ADDR_FLAGS, 8'hff);
    rd(`ADDR_FLAGS, 8'h80);
    halted_i <= 1'b1;
    idle_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(sysclk_en_o, 1'b1, "idle clock on");
    bus(1'b1, `ADDR_FLAGS, 8'h00);
    repeat (2) @(posedge clk_i);
    check(sysclk_en_o, 1'b0, "idle clock off");
    check(pc_sp_clear_o, 1'b0, "no pc clear without timeout");
    halted_i <= 1'b0;
    idle_mode_i <= 1'b0;
    $display("test idle clock done");
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    rd(`ADDR_STATUS, 8'h06);
    watchdog_clear_instruction_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_instruction_i <= 1'b0;
    rd(`ADDR_STATUS, 8'h04);
    $display("test power-down flag done");
    for (int i = 0; i < 4; i++) begin
      r8 = {`KEY_ENABLE, 3'($urandom())};
      bus(1'b1, `ADDR_CONTROL, r8);
      rd(`ADDR_CONTROL, r8);
    end
    bus(1'b1, `ADDR_OPTION, 8'h02);
    bus(1'b1, `ADDR_CONTROL, {`KEY_DISABLE, 3'h3});
    rd(`ADDR_STATUS, 8'h00);
    bus(1'b1, `ADDR_OPTION, 8'h03);
    rd(`ADDR_STATUS, 8'h04);
    bus(1'b1, `ADDR_CONTROL, {`KEY_ENABLE, 3'h3});
    rd(`ADDR_STATUS, 8'h04);
    $display("test key codes done");
    bus(1'b1, `ADDR_CONTROL, {5'h1f, 3'h3});
    wait_rst(1'b1, n);
    check(n >= 1240 && n <= 1890, 1'b1, "key reset delay");
    wait_rst(1'b0, n);
    rd(`ADDR_CONTROL, `CONTROL_RESET);
    rd(`ADDR_FLAGS, 8'h01);
    bus(1'b1, `ADDR_FLAGS, 8'h00);
    rd(`ADDR_FLAGS, 8'h00);
    $display("test illegal key done");
    bus(1'b1, `ADDR_THRESHOLD, `THRESH_CODE_C);
    rd(`ADDR_THRESHOLD, `THRESH_CODE_C);
    bus(1'b1, `ADDR_THRESHOLD, 8'h12);
    wait_rst(1'b1, n);
    check(n >= 1240 && n <= 1890, 1'b1, "threshold reset delay");
    wait_rst(1'b0, n);
    rd(`ADDR_THRESHOLD, `THRESH_RESET);
    rd(`ADDR_FLAGS, 8'h02);
    $display("test illegal threshold done");
    lvr_event_i <= 1'b1;
    wait_rst(1'b1, n);
    check(n < 10, 1'b1, "low voltage reset");
    lvr_event_i <= 1'b0;
    wait_rst(1'b0, n);
    rd(`ADDR_FLAGS, 8'h06);
    $display("test low voltage done");
    reset_pin_i <= 1'b0;
    wait_rst(1'b1, n);
    check(n < 10, 1'b1, "pin reset");
    repeat (30) @(posedge clk_i);
    check(core_reset_o, 1'b1, "pin holds core");
    check(port_bit_o, 1'b0, "pin level");
    reset_pin_i <= 1'b1;
    wait_rst(1'b0, n);
    check(n >= 20 && n <= 30, 1'b1, "pin release delay");
    $display("test reset pin done");
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule
